// ### src/vfcd_dma.sv
`timescale 1ns/1ns
// Overview of operation
// - two channels, odd and even field
// - channel fetches its instruction list from memory
// - pixel writes placed at any byte address
// - clipped pixels make no bus cycles
// - packed or planar chosen per field
// - packed: components interleaved in one region
// - planar: three streams, three regions
// - fields interleaved or in separate buffers
// - bus writes are 32-bit words
// - pixel fifo absorbs bus latency
// - after overrun resume at next pixel
module vfcd_dma import vfcd_pkg::*; #(
	parameter int FIFO_DEPTH = VFCD_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pix_valid,
	input vfcd_pix_t pix,
	input vfcd_chcfg_t [VFCD_NUM_CH-1:0] cfg,
	output vfcd_bus_t bus,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata,
	input wire logic ovr_clr,
	output logic ovr_evt,
	output logic ovr_flag,
	output logic busy,
	output logic cur_field
);
	localparam int EW = $bits(vfcd_ent_t);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		vfcd_st_t st;
		vfcd_st_t ret;
		logic field;
		logic planar;
		logic clip;
		logic abort;
		logic [31:0] pc;
		logic [1:0] fidx;
		logic [VFCD_CNT_W-1:0] cnt;
		logic [2:0][31:0] addr;
		logic [2:0][29:0] wa;
		logic [2:0][31:0] word;
		logic [2:0][3:0] be;
		logic [1:0] wsel;
		logic gld;
		logic [2:0][7:0] gap;
		logic drop;
		logic [2:0][7:0] gacc;
		logic ovr_evt;
		logic ovr_flag;
		vfcd_bus_t bus;
	} vfcd_dma_st_t;

	vfcd_dma_st_t q, n;
	vfcd_ent_t head, push_ent;
	logic f_empty, f_full, f_push, f_pop;
	logic [2:0] gsel, bsel;
	logic [1:0] hs, gs;
	logic [31:0] start_pc;

	// ****************************************
	// pixel fifo
	// ****************************************
	// stream buffering
	vfcd_fifo #(.W(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.push(f_push),
		.wdata(push_ent),
		.pop(f_pop),
		.rdata(head),
		.full(f_full),
		.empty(f_empty)
	);

	function automatic logic [2:0] first_gap(input logic [2:0][7:0] g);
		logic [2:0] r;
		r = '0;
		for (int i = 2; i >= 0; i--) begin
			if (g[i] != '0) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [2:0] first_be(input logic [2:0][3:0] b);
		logic [2:0] r;
		r = '0;
		for (int i = 2; i >= 0; i--) begin
			if (b[i] != '0) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	// packed folds all components into stream 0
	// planar keeps one stream per component
	function automatic logic [1:0] smap(input logic planar, input logic [1:0] c);
		return (planar && c != 2'h3) ? c : 2'h0;
	endfunction

	function automatic vfcd_bus_t mk_wr(input logic [29:0] wa, input logic [3:0] be, input logic [31:0] w);
		vfcd_bus_t b;
		b.req = 1'b1;
		b.we = 1'b1;
		b.addr = {wa, 2'b00};
		b.be = be;
		b.wdata = w;
		return b;
	endfunction

	assign gsel = first_gap(q.gap);
	assign bsel = first_be(q.be);
	assign gs = gsel[1:0];
	assign hs = smap(q.planar, head.pix.comp);
	// each field has its own list, so same or separate buffers
	assign start_pc = cfg[head.pix.field].prog;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		n = q;
		f_pop = 1'b0;
		f_push = 1'b0;
		push_ent = '0;
		n.ovr_evt = 1'b0;
		// capture side: continuous stream, no back-pressure possible
		if (pix_valid) begin
			if (f_full) begin
				n.ovr_evt = 1'b1;
				n.drop = 1'b1;
				if (!pix.sof && q.gacc[pix.comp[1] ? 2 : pix.comp] != VFCD_GAP_MAX) begin
					n.gacc[pix.comp[1] ? 2 : pix.comp] = q.gacc[pix.comp[1] ? 2 : pix.comp] + 8'h01;
				end
			end else if (q.drop && !pix.sof && pix.comp != 2'h0) begin
				// hold off until a pixel boundary
				if (q.gacc[pix.comp[1] ? 2 : pix.comp] != VFCD_GAP_MAX) begin
					n.gacc[pix.comp[1] ? 2 : pix.comp] = q.gacc[pix.comp[1] ? 2 : pix.comp] + 8'h01;
				end
			end else begin
				f_push = 1'b1;
				push_ent.pix = pix;
				// dropped bytes travel as a gap to keep alignment
				push_ent.gap = pix.sof ? '0 : q.gacc;
				n.gacc = '0;
				n.drop = 1'b0;
			end
		end
		// set wins over a clear in the same cycle
		n.ovr_flag = (q.ovr_flag & ~ovr_clr) | n.ovr_evt;

		unique case (q.st)
			S_IDLE: begin
				if (!f_empty) begin
					f_pop = 1'b1;
					if (head.pix.sof && cfg[head.pix.field].en) begin
						n.field = head.pix.field;
						n.planar = cfg[head.pix.field].planar;
						n.pc = start_pc;
						n.fidx = '0;
						n.abort = 1'b0;
						n.gld = 1'b0;
						n.be = '0;
						n.st = S_FETCH;
					end
				end
			end
			S_FETCH: begin
				if (!q.bus.req) begin
					n.bus = '0;
					n.bus.req = 1'b1;
					n.bus.addr = q.pc;
				end else if (bus_ack) begin
					n.bus.req = 1'b0;
					n.pc = q.pc + 32'h4;
					if (q.fidx == '0) begin
						n.cnt = bus_rdata[VFCD_CNT_LSB +: VFCD_CNT_W];
						if (bus_rdata[VFCD_OP_LSB +: 4] == VFCD_OP_WRITE) begin
							n.clip = 1'b0;
							n.fidx = 2'h1;
						end else if (bus_rdata[VFCD_OP_LSB +: 4] == VFCD_OP_SKIP) begin
							n.clip = 1'b1;
							n.st = S_EXEC;
						end else begin
							// end of list or unknown op closes the field
							n.st = S_IDLE;
						end
					end else begin
						n.addr[q.fidx - 2'h1] = bus_rdata;
						if (q.fidx == (q.planar ? VFCD_NADDR_PLANAR : VFCD_NADDR_PACKED)) begin
							n.st = S_EXEC;
						end else begin
							n.fidx = q.fidx + 2'h1;
						end
					end
				end
			end
			S_EXEC: begin
				if (q.cnt == '0) begin
					n.st = S_FLUSH;
				end else if (!f_empty && head.pix.sof) begin
					// new field arrived early: drop rest of list
					n.abort = 1'b1;
					n.st = S_FLUSH;
				end else if (!f_empty && !q.gld) begin
					n.gap = head.gap;
					n.gld = 1'b1;
				end else if (!f_empty && gsel[2]) begin
					// step over lost bytes without bus cycles
					if (q.be[smap(q.planar, gs)] != '0) begin
						n.wsel = smap(q.planar, gs);
						n.bus = mk_wr(q.wa[n.wsel], q.be[n.wsel], q.word[n.wsel]);
						n.ret = S_EXEC;
						n.st = S_WRITE;
					end else begin
						n.addr[smap(q.planar, gs)] = q.addr[smap(q.planar, gs)] + 32'h1;
						n.gap[gs] = q.gap[gs] - 8'h01;
						n.cnt = q.cnt - 1'b1;
					end
				end else if (!f_empty && q.be[hs] != '0 && q.clip) begin
					// partial word must go out before a clipped hole
					n.wsel = hs;
					n.bus = mk_wr(q.wa[hs], q.be[hs], q.word[hs]);
					n.ret = S_EXEC;
					n.st = S_WRITE;
				end else if (!f_empty && q.clip) begin
					// clipped byte only moves the address
					n.addr[hs] = q.addr[hs] + 32'h1;
					n.cnt = q.cnt - 1'b1;
					n.gld = 1'b0;
					f_pop = 1'b1;
				end else if (!f_empty) begin
					// byte lane from address low bits
					n.word[hs][8*q.addr[hs][1:0] +: 8] = head.pix.data;
					n.be[hs][q.addr[hs][1:0]] = 1'b1;
					n.wa[hs] = q.addr[hs][31:2];
					n.addr[hs] = q.addr[hs] + 32'h1;
					n.cnt = q.cnt - 1'b1;
					n.gld = 1'b0;
					f_pop = 1'b1;
					if (q.addr[hs][1:0] == 2'h3) begin
						n.wsel = hs;
						n.bus = mk_wr(n.wa[hs], n.be[hs], n.word[hs]);
						n.ret = S_EXEC;
						n.st = S_WRITE;
					end
				end
			end
			S_WRITE: begin
				if (bus_ack) begin
					n.bus.req = 1'b0;
					n.be[q.wsel] = '0;
					n.st = q.ret;
				end
			end
			S_FLUSH: begin
				if (bsel[2]) begin
					n.wsel = bsel[1:0];
					n.bus = mk_wr(q.wa[bsel[1:0]], q.be[bsel[1:0]], q.word[bsel[1:0]]);
					n.ret = S_FLUSH;
					n.st = S_WRITE;
				end else begin
					n.fidx = '0;
					n.st = q.abort ? S_IDLE : S_FETCH;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign bus = q.bus;
	assign ovr_evt = q.ovr_evt;
	assign ovr_flag = q.ovr_flag;
	assign busy = (q.st != S_IDLE);
	assign cur_field = q.field;

	// ****************************************
	// checks
	// ****************************************
	chan_start_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.st == S_IDLE && !f_empty && head.pix.sof && cfg[head.pix.field].en
		|=> q.st == S_FETCH && q.pc == $past(start_pc) && q.field == $past(head.pix.field))
		else $error("channel did not start from its field list");
	list_read_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.bus.req && !q.bus.we |-> q.st == S_FETCH)
		else $error("bus read outside list fetch");
	byte_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.bus.req && q.bus.we |-> q.bus.be != 4'h0 && q.bus.addr[1:0] == 2'h0)
		else $error("write without byte enable or unaligned");
	clip_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.st == S_EXEC && q.clip && f_pop |=> !q.bus.req)
		else $error("clipped pixel made a bus cycle");
	mode_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.st != S_IDLE && $past(q.st) != S_IDLE |-> $stable(q.planar))
		else $error("format changed inside a field");
	packed_one_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.bus.req && q.bus.we && !q.planar |-> q.wsel == 2'h0)
		else $error("packed write from a chroma stream");
	planar_split_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.st == S_EXEC && f_pop && q.planar && head.pix.comp != 2'h3 |=> q.be[$past(head.pix.comp)] != 4'h0 || q.clip
		|| q.st == S_WRITE)
		else $error("planar byte landed in wrong stream");
	word_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.bus.req && !bus_ack |=> q.bus.req && $stable(q.bus.addr) && $stable(q.bus.wdata) && $stable(q.bus.be))
		else $error("bus word changed before acknowledge");
	realign_a: assert property (@(posedge clk) disable iff (sys_rst)
		q.drop && pix_valid && !f_full && (pix.comp == 2'h0 || pix.sof) |-> f_push ##1 !q.drop)
		else $error("capture did not resume at pixel start");
	ovr_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
		pix_valid && f_full |=> ovr_evt && ovr_flag)
		else $error("overrun not reported");
endmodule

// ### src/vfcd_pkg.sv
// ****************************************
// shared constants and carriers
// ****************************************
package vfcd_pkg;
	localparam int VFCD_NUM_CH = 2;
	localparam int VFCD_NUM_STR = 3;
	localparam int VFCD_FIFO_DEPTH = 16;
	// instruction word layout
	localparam int VFCD_OP_LSB = 28;
	localparam int VFCD_CNT_LSB = 0;
	localparam int VFCD_CNT_W = 12;
	localparam logic [3:0] VFCD_OP_WRITE = 4'h1;
	localparam logic [3:0] VFCD_OP_SKIP = 4'h2;
	localparam logic [3:0] VFCD_OP_EOL = 4'h3;
	// address words following a write op
	localparam logic [1:0] VFCD_NADDR_PACKED = 2'h1;
	localparam logic [1:0] VFCD_NADDR_PLANAR = 2'h3;
	localparam logic [7:0] VFCD_GAP_MAX = 8'hFF;

	typedef struct packed {
		logic sof;
		logic field;
		logic [1:0] comp;
		logic [7:0] data;
	} vfcd_pix_t;

	typedef struct packed {
		vfcd_pix_t pix;
		logic [2:0][7:0] gap;
	} vfcd_ent_t;

	typedef struct packed {
		logic en;
		logic planar;
		logic [31:0] prog;
	} vfcd_chcfg_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} vfcd_bus_t;

	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_EXEC, S_WRITE, S_FLUSH} vfcd_st_t;
endpackage

// ### src/vfcd_fifo.sv
`timescale 1ns/1ns
module vfcd_fifo import vfcd_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = VFCD_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic push,
	input wire logic [W-1:0] wdata,
	input wire logic pop,
	output logic [W-1:0] rdata,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} vfcd_fifo_st_t;

	vfcd_fifo_st_t q, n;
	logic do_push, do_pop;

	assign full = (q.cnt == (AW+1)'(DEPTH));
	assign empty = (q.cnt == '0);
	assign rdata = q.mem[q.rp];
	// a push while full is refused; the caller counts it as overrun
	assign do_push = push & ~full;
	assign do_pop = pop & ~empty;

	always_comb begin
		n = q;
		if (do_push) begin
			n.mem[q.wp] = wdata;
			n.wp = (q.wp == AW'(DEPTH-1)) ? '0 : q.wp + AW'(1);
		end
		if (do_pop) begin
			n.rp = (q.rp == AW'(DEPTH-1)) ? '0 : q.rp + AW'(1);
		end
		n.cnt = q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (sys_rst) full && push && !pop |=> full && $stable(q.wp))
		else $error("pixel fifo accepted data while full");
endmodule

// ### test/vfcd_mem_model.sv
`timescale 1ns/1ns
// ****************************************
// host memory target on the far side
// ****************************************
module vfcd_mem_model import vfcd_pkg::*; (
	input wire logic clk,
	input vfcd_bus_t bus,
	input wire logic [3:0] max_wait,
	output logic bus_ack,
	output logic [31:0] bus_rdata
);
	logic [7:0] mem [int];
	logic [7:0] wr [int];
	int bad_wr = 0;
	int mseed = 27;
	int wait_n = 0;
	logic [31:0] junk = 32'h5A5A5A5A;
	initial begin
		bus_ack = 1'b0;
		bus_rdata = 32'h0;
	end
	// idle read lines toggle so stale data is never mistaken for a word
	always @(posedge clk) begin
		#2;
		junk = ~junk;
		bus_ack = 1'b0;
		bus_rdata = junk;
		if (bus.req) begin
			if (wait_n > 0) begin
				wait_n--;
			end else begin
				bus_ack = 1'b1;
				wait_n = $unsigned($random(mseed)) % (int'(max_wait) + 1);
				// list words served from host memory
				if (!bus.we) begin
					bus_rdata = {mem[bus.addr + 3], mem[bus.addr + 2], mem[bus.addr + 1], mem[bus.addr]};
				end else begin
					if (bus.addr[1:0] != 2'h0)
						bad_wr++;
					for (int b = 0; b < 4; b++)
						if (bus.be[b]) begin
							mem[bus.addr + b] = bus.wdata[8*b +: 8];
							wr[bus.addr + b] = bus.wdata[8*b +: 8];
						end
				end
			end
		end
	end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
// ****************************************
// capture engine bench
// ****************************************
module tb_top import vfcd_pkg::*;;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic pix_valid = 1'b0;
	vfcd_pix_t pix = '0;
	vfcd_chcfg_t [VFCD_NUM_CH-1:0] cfg = '0;
	vfcd_bus_t bus;
	logic bus_ack;
	logic [31:0] bus_rdata;
	logic ovr_clr = 1'b0;
	logic ovr_evt;
	logic ovr_flag;
	logic busy;
	logic cur_field;
	logic [3:0] max_wait = 4'h2;
	logic [31:0] base;
	int seed = 27;
	int fail_count = 0;
	int checks_done = 0;
	int evt_seen = 0;
	int pc;
	logic [7:0] exp [int];

	always #25 clk = ~clk;
	always @(posedge clk) if (ovr_evt === 1'b1) evt_seen++;

	// small fifo so a slow target overruns quickly
	vfcd_dma #(.FIFO_DEPTH(4)) vfcd_dma_inst (.clk(clk), .sys_rst(sys_rst), .pix_valid(pix_valid), .pix(pix),
		.cfg(cfg), .bus(bus), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .ovr_clr(ovr_clr), .ovr_evt(ovr_evt),
		.ovr_flag(ovr_flag), .busy(busy), .cur_field(cur_field));
	vfcd_mem_model vfcd_mem_model_inst (.clk(clk), .bus(bus), .max_wait(max_wait), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic word(input logic [31:0] w);
		for (int b = 0; b < 4; b++)
			vfcd_mem_model_inst.mem[pc + b] = w[8*b +: 8];
		pc += 4;
	endtask
	function automatic logic [31:0] dest(input logic pl, input logic [31:0] b, input int c, input int k);
		return pl ? b + 32'h400 * c + k : b + k;
	endfunction
	task automatic wait_idle();
		int t;
		t = 0;
		while (busy !== 1'b0 && t < 3000) begin
			step(1);
			t++;
		end
		if (t == 3000) begin
			fail_count++;
			results();
		end
	endtask
	// list: one write, or write, skip, write for clipping
	task automatic prog(input logic f, input logic pl, input int n, input int sa, input int sn);
		base = 32'h10000 + 32'h1000 * f + ($unsigned($random(seed)) % 16);
		exp.delete();
		vfcd_mem_model_inst.wr.delete();
		pc = 32'h100 + 32'h80 * f;
		cfg[f] = '{en: 1'b1, planar: pl, prog: 32'(pc)};
		word({VFCD_OP_WRITE, 16'h0, 12'(sn == 0 ? n : sa)});
		for (int c = 0; c < (pl ? 3 : 1); c++)
			word(dest(pl, base, c, 0));
		if (sn != 0) begin
			word({VFCD_OP_SKIP, 16'h0, 12'(sn)});
			word({VFCD_OP_WRITE, 16'h0, 12'(n - sa - sn)});
			word(base + sa + sn);
		end
		word({VFCD_OP_EOL, 28'h0});
	endtask
	// byte order Y Cb Y Cr; gap idle cycles between bytes
	task automatic feed(input logic f, input logic pl, input int n, input int gap, input int sa, input int sn);
		int k [3];
		int c;
		k = '{0, 0, 0};
		pix = '{sof: 1'b1, field: f, comp: 2'h0, data: 8'h0};
		pix_valid = 1'b1;
		step(1);
		for (int i = 0; i < n; i++) begin
			c = (i % 2 == 0) ? 0 : ((i % 4 == 1) ? 1 : 2);
			pix = '{sof: 1'b0, field: f, comp: 2'(c), data: 8'($random(seed))};
			pix_valid = 1'b1;
			if (i < sa || i >= sa + sn) exp[dest(pl, base, c, pl ? k[c] : i)] = pix.data;
			k[c]++;
			step(1);
			if (gap > 0) begin
				pix_valid = 1'b0;
				step(gap);
			end
		end
		pix_valid = 1'b0;
	endtask
	task automatic run(input logic f, input logic pl, input int n, input int sa, input int sn);
		prog(f, pl, n, sa, sn);
		feed(f, pl, n, 6, sa, sn);
		wait_idle();
		check(32'(cur_field), 32'(f));
		foreach (exp[a]) check(vfcd_mem_model_inst.mem[a], exp[a]);
		check(vfcd_mem_model_inst.wr.size(), exp.size());
		check(vfcd_mem_model_inst.bad_wr, 0);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		step(8);
		sys_rst = 1'b0;
		check({bus.req, busy, ovr_flag, ovr_evt}, 4'h0);
		run(1'b0, 1'b0, 11, 0, 0);
		run(1'b1, 1'b1, 12, 0, 0);
		run(1'b0, 1'b0, 15, 5, 4);
		run(1'b1, 1'b0, 9, 0, 0);
		// disabled field makes no traffic
		cfg[1].en = 1'b0;
		vfcd_mem_model_inst.wr.delete();
		feed(1'b1, 1'b0, 8, 3, 0, 0);
		check(32'(busy), 32'h0);
		check(vfcd_mem_model_inst.wr.size(), 0);
		// slow target, back to back bytes
		max_wait = 4'hF;
		prog(1'b0, 1'b0, 60, 0, 0);
		feed(1'b0, 1'b0, 60, 0, 0, 0);
		check(32'(evt_seen > 0), 32'h1);
		check(32'(ovr_flag), 32'h1);
		ovr_clr = 1'b1;
		step(1);
		ovr_clr = 1'b0;
		step(1);
		check(32'(ovr_flag), 32'h0);
		// give the slow target time to free a slot, else the marker itself is lost
		step(120);
		// a disabled start marker closes the broken run
		feed(1'b1, 1'b0, 0, 0, 0, 0);
		wait_idle();
		// bytes that survived the overrun must sit at their own addresses
		check(32'(vfcd_mem_model_inst.wr.size() > 0), 32'h1);
		foreach (vfcd_mem_model_inst.wr[a]) check(vfcd_mem_model_inst.wr[a], exp[a]);
		max_wait = 4'h2;
		run(1'b0, 1'b1, 16, 0, 0);
		results();
	end
endmodule
